// ---- rtl/indicator_pkg.sv ----
// Constants, phase codes and light modes for the charger status indicator.
// Assumes a 250 MHz mclk; all timing counts derive from it.
package indicator_pkg;
	localparam int unsigned CLK_HZ = 250_000_000;
	localparam int unsigned SLOW_FLASH_HZ = 1;
	localparam int unsigned FAST_FLASH_HZ = 10;
	localparam int unsigned SHORT_BEEP_MS = 100;
	localparam int unsigned LONG_BEEP_MS = 1000;
	// Half periods of the flash clocks, in mclk cycles
	localparam int unsigned SLOW_HALF_CYCLES = CLK_HZ / (2 * SLOW_FLASH_HZ);
	localparam int unsigned FAST_HALF_CYCLES = CLK_HZ / (2 * FAST_FLASH_HZ);
	localparam int unsigned SHORT_BEEP_CYCLES = (CLK_HZ / 1000) * SHORT_BEEP_MS;
	localparam int unsigned LONG_BEEP_CYCLES = (CLK_HZ / 1000) * LONG_BEEP_MS;
	// Last step of the double-flash frame: lit in steps 0 and 2, dark up to here
	localparam logic [2:0] DOUBLE_FRAME_LAST = 3'h7;

	typedef enum logic [3:0] {
		PH_NO_BATTERY = 4'h0,
		PH_DETECT = 4'h1,
		PH_SOFT_START = 4'h2,
		PH_CHARGING = 4'h3,
		PH_TOPPING = 4'h4,
		PH_MAINTENANCE = 4'h5,
		PH_DISCHARGE = 4'h6,
		PH_TEMP_ERROR = 4'h7,
		PH_ERROR = 4'h8
	} phase_t;

	typedef enum logic [2:0] {
		LM_OFF = 3'h0,
		LM_ON = 3'h1,
		LM_SLOW = 3'h2,
		LM_FAST = 3'h3,
		LM_DOUBLE = 3'h4
	} light_mode_t;

	typedef enum logic [1:0] {
		BEEP_NONE = 2'h0,
		BEEP_SHORT = 2'h1,
		BEEP_LONG = 2'h2
	} beep_t;
endpackage : indicator_pkg

// ---- rtl/beep_timer.sv ----
// One-shot beep timer: holds a plain level for a short or long duration.
// Assumes start is a one-cycle pulse; a new start restarts the timer.
`timescale 1ns/1ps
`default_nettype none
module beep_timer #(
	parameter int unsigned SHORT_CYCLES = indicator_pkg::SHORT_BEEP_CYCLES,
	parameter int unsigned LONG_CYCLES = indicator_pkg::LONG_BEEP_CYCLES
) (
	input wire logic mclk,
	input wire logic reset,
	input wire logic start,
	input wire logic long_sel,
	output logic active
);
	logic [27:0] count_q, count_d;
	logic active_q, active_d;

	always_comb begin
		count_d = count_q;
		active_d = active_q;
		if (start) begin
			count_d = long_sel ? 28'(LONG_CYCLES - 1) : 28'(SHORT_CYCLES - 1);
			active_d = 1'b1;
		end else if (active_q) begin
			if (count_q == 28'h0) begin
				active_d = 1'b0;
			end else begin
				count_d = count_q - 28'h1;
			end
		end
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			count_q <= 28'h0;
			active_q <= 1'b0;
		end else begin
			count_q <= count_d;
			active_q <= active_d;
		end
	end

	assign active = active_q;
endmodule : beep_timer
`default_nettype wire

// ---- rtl/charger_status_indicator.sv ----
// Status lights and buzzer level for a battery charge controller.
// Assumes phase and li_ion_mode come synchronous to mclk from the charge sequencer.
`timescale 1ns/1ps
`default_nettype none
module charger_status_indicator #(
	parameter int unsigned SLOW_HALF = indicator_pkg::SLOW_HALF_CYCLES,
	parameter int unsigned FAST_HALF = indicator_pkg::FAST_HALF_CYCLES,
	parameter int unsigned SHORT_BEEP = indicator_pkg::SHORT_BEEP_CYCLES,
	parameter int unsigned LONG_BEEP = indicator_pkg::LONG_BEEP_CYCLES
) (
	input wire logic mclk,
	input wire logic reset,
	input wire logic [3:0] phase,
	input wire logic li_ion_mode,
	output logic status_light_a,
	output logic status_light_b,
	output logic status_light_c,
	output logic buzzer
);
	// Flash timebase state
	logic [27:0] slow_cnt_q, slow_cnt_d;
	logic [27:0] fast_cnt_q, fast_cnt_d;
	logic slow_q, slow_d;
	logic fast_q, fast_d;
	logic [2:0] dbl_step_q, dbl_step_d;
	// Phase tracking and outputs
	logic [3:0] prev_phase_q, prev_phase_d;
	logic first_q, first_d;
	logic light_a_q, light_a_d;
	logic light_b_q, light_b_d;
	logic light_c_q, light_c_d;
	logic buzzer_q, buzzer_d;
	logic phase_change;
	logic beep_start;
	logic beep_long;
	logic beep_active;
	indicator_pkg::light_mode_t mode_a, mode_b, mode_c;
	indicator_pkg::beep_t beep_kind;

	// Pattern table per phase and chemistry
	always_comb begin
		mode_a = indicator_pkg::LM_OFF;
		mode_b = indicator_pkg::LM_OFF;
		mode_c = indicator_pkg::LM_OFF;
		beep_kind = indicator_pkg::BEEP_NONE;
		unique case (phase)
			indicator_pkg::PH_DETECT: begin
				mode_a = indicator_pkg::LM_FAST;
				beep_kind = indicator_pkg::BEEP_SHORT;
			end
			indicator_pkg::PH_SOFT_START: begin
				mode_a = indicator_pkg::LM_SLOW;
			end
			indicator_pkg::PH_CHARGING: begin
				mode_a = indicator_pkg::LM_ON;
				mode_b = indicator_pkg::LM_SLOW;
			end
			indicator_pkg::PH_TOPPING: begin
				mode_a = indicator_pkg::LM_ON;
				mode_b = indicator_pkg::LM_FAST;
			end
			indicator_pkg::PH_MAINTENANCE: begin
				mode_a = indicator_pkg::LM_ON;
				mode_c = indicator_pkg::LM_ON;
				beep_kind = indicator_pkg::BEEP_LONG;
			end
			indicator_pkg::PH_DISCHARGE: begin
				// Lithium has no discharge phase; lights stay off there
				if (!li_ion_mode) begin
					mode_b = indicator_pkg::LM_SLOW;
				end
			end
			indicator_pkg::PH_TEMP_ERROR: begin
				mode_a = indicator_pkg::LM_DOUBLE;
				mode_c = indicator_pkg::LM_ON;
				beep_kind = indicator_pkg::BEEP_SHORT;
			end
			indicator_pkg::PH_ERROR: begin
				mode_a = indicator_pkg::LM_FAST;
				mode_c = indicator_pkg::LM_FAST;
				beep_kind = indicator_pkg::BEEP_SHORT;
			end
			default: begin
				// No battery and unused codes: everything off
				mode_a = indicator_pkg::LM_OFF;
			end
		endcase
	end

	function automatic logic light_level(input indicator_pkg::light_mode_t m, input logic slow,
		input logic fast, input logic [2:0] step);
		logic v;
		v = 1'b0;
		unique case (m)
			indicator_pkg::LM_ON: v = 1'b1;
			indicator_pkg::LM_SLOW: v = slow;
			indicator_pkg::LM_FAST: v = fast;
			// Steps 0 and 2 lit, 1 and 3..7 dark
			indicator_pkg::LM_DOUBLE: v = (step == 3'h0) || (step == 3'h2);
			default: v = 1'b0;
		endcase
		return v;
	endfunction

	// First edge after reset counts as a phase entry
	assign phase_change = first_q || (phase != prev_phase_q);
	assign beep_start = phase_change && (beep_kind != indicator_pkg::BEEP_NONE);
	assign beep_long = (beep_kind == indicator_pkg::BEEP_LONG);

	// Flash timebases restart on each phase change
	always_comb begin
		slow_cnt_d = slow_cnt_q;
		fast_cnt_d = fast_cnt_q;
		slow_d = slow_q;
		fast_d = fast_q;
		dbl_step_d = dbl_step_q;
		if (phase_change) begin
			slow_cnt_d = 28'h0;
			fast_cnt_d = 28'h0;
			slow_d = 1'b1;
			fast_d = 1'b1;
			dbl_step_d = 3'h0;
		end else begin
			if (slow_cnt_q == 28'(SLOW_HALF - 1)) begin
				slow_cnt_d = 28'h0;
				slow_d = !slow_q;
			end else begin
				slow_cnt_d = slow_cnt_q + 28'h1;
			end
			if (fast_cnt_q == 28'(FAST_HALF - 1)) begin
				fast_cnt_d = 28'h0;
				fast_d = !fast_q;
				dbl_step_d = (dbl_step_q == indicator_pkg::DOUBLE_FRAME_LAST) ? 3'h0 :
					dbl_step_q + 3'h1;
			end else begin
				fast_cnt_d = fast_cnt_q + 28'h1;
			end
		end
	end

	// Output registers
	always_comb begin
		prev_phase_d = phase;
		first_d = 1'b0;
		light_a_d = light_level(mode_a, slow_d, fast_d, dbl_step_d);
		light_b_d = light_level(mode_b, slow_d, fast_d, dbl_step_d);
		light_c_d = light_level(mode_c, slow_d, fast_d, dbl_step_d);
		buzzer_d = beep_active;
	end

	// Timebase registers
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			slow_cnt_q <= 28'h0;
			fast_cnt_q <= 28'h0;
			slow_q <= 1'b0;
			fast_q <= 1'b0;
			dbl_step_q <= 3'h0;
		end else begin
			slow_cnt_q <= slow_cnt_d;
			fast_cnt_q <= fast_cnt_d;
			slow_q <= slow_d;
			fast_q <= fast_d;
			dbl_step_q <= dbl_step_d;
		end
	end

	// Phase tracking and output registers
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			prev_phase_q <= 4'h0;
			first_q <= 1'b1;
			light_a_q <= 1'b0;
			light_b_q <= 1'b0;
			light_c_q <= 1'b0;
			buzzer_q <= 1'b0;
		end else begin
			prev_phase_q <= prev_phase_d;
			first_q <= first_d;
			light_a_q <= light_a_d;
			light_b_q <= light_b_d;
			light_c_q <= light_c_d;
			buzzer_q <= buzzer_d;
		end
	end

	// A running beep finishes when the phase moves to a silent phase; entering a phase with its own beep restarts the timer
	beep_timer #(
		.SHORT_CYCLES(SHORT_BEEP),
		.LONG_CYCLES(LONG_BEEP)
	) u_beep (
		.mclk(mclk),
		.reset(reset),
		.start(beep_start),
		.long_sel(beep_long),
		.active(beep_active)
	);

	assign status_light_a = light_a_q;
	assign status_light_b = light_b_q;
	assign status_light_c = light_c_q;
	assign buzzer = buzzer_q;
endmodule : charger_status_indicator
`default_nettype wire

// ---- bench/status_chk.sv ----
// Checker for the status light and buzzer outputs.
// Assumes binding to the top module; parameters follow the instance.
`timescale 1ns/1ps
`default_nettype none
module status_chk #(
	parameter int unsigned SLOW_HALF = 40,
	parameter int unsigned FAST_HALF = 8,
	parameter int unsigned SHORT_BEEP = 20,
	parameter int unsigned LONG_BEEP = 60
) (
	input wire logic mclk,
	input wire logic reset,
	input wire logic [3:0] phase,
	input wire logic li_ion_mode,
	input wire logic status_light_a,
	input wire logic status_light_b,
	input wire logic status_light_c,
	input wire logic buzzer
);
	logic [31:0] hi_q, hi_d, st_q, st_d;
	logic [3:0] prev_q;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);
	always_comb begin
		hi_d = buzzer ? hi_q + 32'h1 : 32'h0;
		st_d = (phase == prev_q) ? st_q + 32'h1 : 32'h0;
	end
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			hi_q <= 32'h0;
			st_q <= 32'h0;
			prev_q <= 4'hf;
		end else begin
			hi_q <= hi_d;
			st_q <= st_d;
			prev_q <= phase;
		end
	end
	a_nobat_dark: assert property (phase == 4'h0 |=> !status_light_a && !status_light_b && !status_light_c)
		else $error("lit with no battery");
	a_maint_lights: assert property (phase == 4'h5 |=> status_light_a && !status_light_b && status_light_c)
		else $error("maintenance lights wrong");
	a_temp_lights: assert property (phase == 4'h7 |=> !status_light_b && status_light_c)
		else $error("temperature lights wrong");
	a_error_pair: assert property (phase == 4'h8 |=> status_light_a == status_light_c && !status_light_b)
		else $error("error lights wrong");
	a_beep_entry: assert property (phase == 4'h5 && phase != prev_q |-> ##2 buzzer)
		else $error("long beep missing");
	a_beep_len: assert property ($fell(buzzer) |-> hi_q == SHORT_BEEP || hi_q == LONG_BEEP)
		else $error("beep length wrong");
	a_no_repeat: assert property ($rose(buzzer) |-> $past(st_q) == 32'h0)
		else $error("beep without entry");
	a_fast_period: assert property ($rose(status_light_a) && phase == 4'h1 && st_q > 32'h20
		|-> !$past(status_light_a, FAST_HALF) && $past(status_light_a, FAST_HALF + 1))
		else $error("fast flash period wrong");
	c_long: cover property ($fell(buzzer) && hi_q == LONG_BEEP);
	c_double: cover property (phase == 4'h7 ##1 $rose(status_light_a));
	c_discharge: cover property (phase == 4'h6 && !li_ion_mode ##1 status_light_b);
endmodule : status_chk
`default_nettype wire

// ---- bench/indicator_load.sv ----
// Load model: a self-oscillating buzzer counting its beeps.
// Assumes the buzzer line is an active-high level sampled on mclk.
`timescale 1ns/1ps
`default_nettype none
module indicator_load (
	input wire logic mclk,
	input wire logic buzzer,
	output var int beeps,
	output var int beep_len
);
	int run = 0;
	// Sounds for as long as the level is held, no tone needed
	always @(posedge mclk) begin
		if (buzzer && run == 0)
			beeps <= beeps + 1;
		if (!buzzer && run != 0)
			beep_len <= run;
		run <= buzzer ? run + 1 : 0;
	end
endmodule : indicator_load
`default_nettype wire

// ---- bench/charger_status_indicator_tb.sv ----
// Testbench for the charger status indicator with shortened timing.
// Assumes the load model and checker files are compiled first.
`timescale 1ns/1ps
`default_nettype none
module charger_status_indicator_tb;
	localparam int SH = 40, FH = 8, SB = 20, LB = 60;
	logic mclk = 1'b0, reset = 1'b1, li = 1'b0;
	logic [3:0] phase = 4'h0;
	logic a, b, c, bz;
	int fail_count = 0, check_count = 0, cyc = 0, beeps, beep_len, n0;
	// Rows: li, phase, lights a b c, beep 0 none 1 short 2 long
	logic [9:0] rows [18] = '{10'h000, 10'h031, 10'h050, 10'h078, 10'h098, 10'h0b6, 10'h0c8,
		10'h0f5, 10'h115, 10'h200, 10'h231, 10'h250, 10'h278, 10'h298, 10'h2b6, 10'h2c0,
		10'h2f5, 10'h315};
	charger_status_indicator #(.SLOW_HALF(SH), .FAST_HALF(FH), .SHORT_BEEP(SB), .LONG_BEEP(LB))
		i_charger_status_indicator (.mclk(mclk), .reset(reset), .phase(phase),
		.li_ion_mode(li), .status_light_a(a), .status_light_b(b), .status_light_c(c), .buzzer(bz));
	indicator_load i_indicator_load (.mclk(mclk), .buzzer(bz), .beeps(beeps), .beep_len(beep_len));
	always #2 mclk = ~mclk;
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
		end
	endtask : check
	task automatic results();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : results
	task automatic pat(input logic [3:0] ph, input int half, input logic [7:0] p);
		phase = 4'h0;
		repeat (2) @(negedge mclk);
		phase = ph;
		repeat (1 + half / 2) @(negedge mclk);
		for (int k = 0; k < 8; k++) begin
			check(a, p[k]);
			repeat (half) @(negedge mclk);
		end
		$display("pattern %0h done", ph);
	endtask : pat
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			fail_count++;
			results();
		end
	end
	initial begin
		repeat (16) @(posedge mclk);
		@(negedge mclk);
		reset = 1'b0;
		for (int i = 0; i < 18; i++) begin
			n0 = beeps;
			li = rows[i][9];
			phase = rows[i][8:5];
			repeat (2) @(negedge mclk);
			check({a, b, c}, rows[i][4:2]);
			repeat (80) @(negedge mclk);
			check(beeps - n0, rows[i][1:0] != 2'h0);
			if (rows[i][1:0] != 2'h0)
				check(beep_len, rows[i][1] ? LB : SB);
			$display("row %0d done", i);
		end
		pat(4'h1, FH, 8'h55);
		pat(4'h2, SH, 8'h55);
		pat(4'h7, FH, 8'h05);
		phase = 4'h5;
		repeat (30) @(negedge mclk);
		reset = 1'b1;
		@(negedge mclk);
		check({a, b, c, bz}, 4'h0);
		n0 = beeps;
		reset = 1'b0;
		repeat (3) @(negedge mclk);
		check(beeps - n0, 1);
		check({a, b, c, bz}, 4'hb);
		repeat (70) @(negedge mclk);
		check(beep_len, LB);
		$display("reset done");
		phase = 4'hb;
		repeat (2) @(negedge mclk);
		check({a, b, c, bz}, 4'h0);
		$display("unused code done");
		results();
	end
endmodule : charger_status_indicator_tb
bind charger_status_indicator status_chk #(.SLOW_HALF(SLOW_HALF), .FAST_HALF(FAST_HALF),
	.SHORT_BEEP(SHORT_BEEP), .LONG_BEEP(LONG_BEEP)) i_status_chk (.mclk(mclk), .reset(reset),
	.phase(phase), .li_ion_mode(li_ion_mode), .status_light_a(status_light_a),
	.status_light_b(status_light_b), .status_light_c(status_light_c), .buzzer(buzzer));
`default_nettype wire
